// file: hw/pse_pkg.sv
// Package with register map, field positions and reset values of the status block
package pse_pkg;
   // Register indices (printed offsets) and byte addresses
   localparam logic [7:0] STATUS_IDX      = 8'h11;
   localparam logic [7:0] ENABLE_IDX      = 8'h12;
   localparam logic [7:0] PENDING_IDX     = 8'h13;
   localparam logic [7:0] IRQ_CFG_IDX     = 8'h14;
   localparam logic [9:0] STATUS_ADDR     = {STATUS_IDX, 2'b00};
   localparam logic [9:0] ENABLE_ADDR     = {ENABLE_IDX, 2'b00};
   localparam logic [9:0] PENDING_ADDR    = {PENDING_IDX, 2'b00};
   localparam logic [9:0] IRQ_CFG_ADDR    = {IRQ_CFG_IDX, 2'b00};
   // Status register field positions
   localparam int RATE_HI        = 15;
   localparam int RATE_LO        = 14;
   localparam int DUPLEX_BIT     = 13;
   localparam int PAGE_BIT       = 12;
   localparam int RESOLVED_BIT   = 11;
   localparam int LINK_BIT       = 10;
   localparam int CROSS_CD_BIT   = 9;
   localparam int CROSS_AB_BIT   = 8;
   localparam int GIG_MASK_BIT   = 7;
   localparam int SLEEP_BIT      = 6;
   localparam int CHPOL_HI       = 5;
   localparam int CHPOL_LO       = 2;
   localparam int POL10_BIT      = 1;
   localparam int JABBER_BIT     = 0;
   // Event / enable bit positions
   localparam int EV_NEG_FAULT   = 15;
   localparam int EV_RATE        = 14;
   localparam int EV_DUPLEX      = 13;
   localparam int EV_PAGE        = 12;
   localparam int EV_NEG_DONE    = 11;
   localparam int EV_LINK        = 10;
   localparam int EV_FALSE_CAR   = 8;
   localparam int EV_PAIR_SWAP   = 6;
   localparam int EV_DOWNSHIFT   = 5;
   localparam int EV_DOZE        = 4;
   localparam int EV_WAKE        = 3;
   localparam int EV_MAC_IF_ERR  = 2;
   localparam int EV_POL         = 1;
   localparam int EV_JABBER      = 0;
   // Writable enables; bits 9 and 7 are reserved
   localparam logic [15:0] ENABLE_WMASK   = 16'hfd7f;
   localparam logic [15:0] ENABLE_RESET   = 16'h0000;
   localparam logic [15:0] PENDING_RESET  = 16'h0000;
   localparam logic        POL10_RESET    = 1'b1;
   localparam int          IRQ_LOW_BIT    = 13;
   localparam logic        IRQ_LOW_RESET  = 1'b1;
   localparam logic [31:0] UNMAPPED_DATA  = 32'h0000_0000;
endpackage

// file: hw/pse_sync.sv
// Two-flop synchroniser for a vector of level inputs
`timescale 1ns/100ps
module pse_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] INIT = '0
) (
   input  wire logic             core_clk,
   input  wire logic             rst,
   input  wire logic             clk_en,
   input  wire logic [WIDTH-1:0] d,
   output logic      [WIDTH-1:0] q
);
   logic [WIDTH-1:0] meta_ff;
   logic [WIDTH-1:0] q_ff;

   // First stage read only by the second stage
   always_ff @(posedge core_clk) begin
      if (rst) begin
         meta_ff <= INIT;
         q_ff    <= INIT;
      end else if (clk_en) begin
         meta_ff <= d;
         q_ff    <= meta_ff;
      end
   end

   assign q = q_ff;
endmodule

// file: hw/pse_top.sv
// Status summary and event enable registers with interrupt output, Avalon-MM slave
// Overview of operation
// - status bits 15:14 give speed: 00 10M, 01 100M, 10 1000M, 11 reserved.
// - status bit 13 shows full duplex as one, half as zero; resets zero.
// - status bit 12 latches page received until the status register is read.
// - status bit 11 is one when negotiation finished or disabled.
// - status bit 10 shows link up; resets zero.
// - bit 9 gives C/D crossover, bit 8 gives A/B crossover resolution.
// - bit 7 is one while negotiating with gigabit abilities masked.
// - bit 6 is one while the device sleeps.
// - bits 5:2 show reversed polarity of channels D..A in gigabit link.
// - bit 1 shows 10 Mbps polarity correct as one; resets one.
// - bit 0 mirrors jabber detect; reading status does not clear it.
// - interrupt only for events whose enable bit is set.
// - enable bits 15..10 are read-write, reset zero.
// - enable bits 8,6,5,4,3 are read-write, reset zero.
// - enable bits 9 and 7 read zero and ignore writes.
// - enable bits 2,1,0 are read-write, reset zero.
// - pending bits set regardless of enable; cleared by reading pending register.
// - interrupt active low by default; config bit clear selects active high.
`timescale 1ns/100ps
module pse_top (
   input  wire logic        core_clk,
   input  wire logic        rst,
   input  wire logic        clk_en,
   // Avalon-MM slave
   input  wire logic [9:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic      [31:0] avs_readdata,
   output logic             avs_waitrequest,
   // Live PHY state, from outside this clock domain
   input  wire logic [1:0]  rate_in,
   input  wire logic        full_duplex_in,
   input  wire logic        neg_resolved_in,
   input  wire logic        link_up_in,
   input  wire logic        cross_resolved_pairs_cd,
   input  wire logic        cross_resolved_pairs_ab,
   input  wire logic        gig_masking_active,
   input  wire logic        doze_in,
   input  wire logic [3:0]  channel_polarity_reversed,
   input  wire logic        pol10_correct_in,
   input  wire logic        jabber_in,
   // Event pulses from same-domain logic
   input  wire logic        page_rx_evt,
   input  wire logic        neg_fault_evt,
   input  wire logic        neg_done_evt,
   input  wire logic        false_carrier_evt,
   input  wire logic        downshift_evt,
   input  wire logic        wake_packet_evt,
   input  wire logic        mac_if_error_evt,
   // Interrupt pin level
   output logic             irq_pin
);
   // Synchronised live state
   logic [1:0]  rate_s;
   logic        duplex_s;
   logic        resolved_s;
   logic        link_s;
   logic        cd_s;
   logic        ab_s;
   logic        gmask_s;
   logic        doze_s;
   logic [3:0]  chpol_s;
   logic        pol10_s;
   logic        jabber_s;
   logic [17:0] sync_in;
   logic [17:0] sync_out;

   // Registers
   logic [15:0] event_enable_mask_ff;
   logic [15:0] event_pending_reg_ff;
   logic        page_latch_ff;
   logic        irq_low_ff;
   logic        irq_pin_ff;
   logic [31:0] rdata_ff;
   logic        ack_ff;
   logic [17:0] prev_ff;
   logic [2:0]  fill_ff;

   // Single synchroniser; polarity bit resets one so no false event at start
   assign sync_in = {rate_in, full_duplex_in, neg_resolved_in, link_up_in,
                     cross_resolved_pairs_cd, cross_resolved_pairs_ab,
                     gig_masking_active, doze_in, channel_polarity_reversed,
                     pol10_correct_in, jabber_in, 3'b000};

   pse_sync #(
      .WIDTH (18),
      .INIT  (18'h00010)
   ) u_sync (
      .core_clk (core_clk),
      .rst      (rst),
      .clk_en   (clk_en),
      .d        (sync_in),
      .q        (sync_out)
   );

   assign rate_s     = sync_out[17:16];
   assign duplex_s   = sync_out[15];
   assign resolved_s = sync_out[14];
   assign link_s     = sync_out[13];
   assign cd_s       = sync_out[12];
   assign ab_s       = sync_out[11];
   assign gmask_s    = sync_out[10];
   assign doze_s     = sync_out[9];
   assign chpol_s    = sync_out[8:5];
   assign pol10_s    = sync_out[4];
   assign jabber_s   = sync_out[3];

   // Bus decode; every access answers one cycle after it is seen
   logic        access;
   logic        rd_fire;
   logic        wr_fire;
   logic        hit_status;
   logic        hit_enable;
   logic        hit_pending;
   logic        hit_cfg;
   logic [15:0] lane_mask;
   assign access      = (avs_read | avs_write) & ~ack_ff;
   assign rd_fire     = avs_read & ~ack_ff & clk_en;
   assign wr_fire     = avs_write & ~ack_ff & clk_en;
   assign hit_status  = avs_address == pse_pkg::STATUS_ADDR;
   assign hit_enable  = avs_address == pse_pkg::ENABLE_ADDR;
   assign hit_pending = avs_address == pse_pkg::PENDING_ADDR;
   assign hit_cfg     = avs_address == pse_pkg::IRQ_CFG_ADDR;
   assign lane_mask   = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

   // Status word assembly
   logic [15:0] status_word;
   assign status_word[pse_pkg::RATE_HI:pse_pkg::RATE_LO]   = rate_s;
   assign status_word[pse_pkg::DUPLEX_BIT]                 = duplex_s;
   assign status_word[pse_pkg::PAGE_BIT]                   = page_latch_ff;
   assign status_word[pse_pkg::RESOLVED_BIT]               = resolved_s;
   assign status_word[pse_pkg::LINK_BIT]                   = link_s;
   assign status_word[pse_pkg::CROSS_CD_BIT]               = cd_s;
   assign status_word[pse_pkg::CROSS_AB_BIT]               = ab_s;
   assign status_word[pse_pkg::GIG_MASK_BIT]               = gmask_s;
   assign status_word[pse_pkg::SLEEP_BIT]                  = doze_s;
   assign status_word[pse_pkg::CHPOL_HI:pse_pkg::CHPOL_LO] = chpol_s;
   assign status_word[pse_pkg::POL10_BIT]                  = pol10_s;
   assign status_word[pse_pkg::JABBER_BIT]                 = jabber_s;

   // Change detection on live state; masked until the synchroniser has refilled
   logic        rate_chg;
   logic        duplex_chg;
   logic        link_chg;
   logic        cross_chg;
   logic        doze_chg;
   logic        pol_chg;
   logic        jab_rise;
   logic [17:0] diff;
   assign diff       = (sync_out ^ prev_ff) & {18{fill_ff[2]}};
   assign rate_chg   = |diff[17:16];
   assign duplex_chg = diff[15];
   assign link_chg   = diff[13];
   assign cross_chg  = |diff[12:11];
   assign doze_chg   = diff[9];
   assign pol_chg    = |diff[8:4];
   assign jab_rise   = diff[3] & sync_out[3];

   // Event vector in pending-bit layout
   logic [15:0] events;
   assign events = {neg_fault_evt, rate_chg, duplex_chg, page_rx_evt,
                    neg_done_evt, link_chg, 1'b0, false_carrier_evt,
                    1'b0, cross_chg, downshift_evt, doze_chg,
                    wake_packet_evt, mac_if_error_evt, pol_chg, jab_rise};

   // Next values; set beats the read clear in the same cycle
   logic [15:0] nxt_event_pending_reg;
   logic        nxt_page_latch;
   logic [15:0] nxt_event_enable_mask;
   logic        nxt_irq_low;
   logic        irq_active;
   logic        nxt_irq_pin;
   assign nxt_event_pending_reg = ((rd_fire & hit_pending) ? 16'h0000
                                   : event_pending_reg_ff) | events;
   assign nxt_page_latch = ((rd_fire & hit_status) ? 1'b0 : page_latch_ff)
                           | page_rx_evt;
   assign nxt_event_enable_mask = (wr_fire & hit_enable)
      ? ((event_enable_mask_ff & ~(lane_mask & pse_pkg::ENABLE_WMASK))
         | (avs_writedata[15:0] & lane_mask & pse_pkg::ENABLE_WMASK))
      : event_enable_mask_ff;
   assign nxt_irq_low = (wr_fire & hit_cfg & avs_byteenable[1])
                        ? avs_writedata[pse_pkg::IRQ_LOW_BIT] : irq_low_ff;
   assign irq_active  = |(event_pending_reg_ff & event_enable_mask_ff);
   assign nxt_irq_pin = irq_low_ff ? ~irq_active : irq_active;

   // Read mux; writes to status fall through unused
   logic [31:0] nxt_rdata;
   assign nxt_rdata = hit_status  ? {16'h0000, status_word}
                    : hit_enable  ? {16'h0000, event_enable_mask_ff}
                    : hit_pending ? {16'h0000, event_pending_reg_ff}
                    : hit_cfg     ? {18'h00000, irq_low_ff, 13'h0000}
                    : pse_pkg::UNMAPPED_DATA;

   // Register state
   always_ff @(posedge core_clk) begin
      if (rst) begin
         event_enable_mask_ff <= pse_pkg::ENABLE_RESET;
         event_pending_reg_ff <= pse_pkg::PENDING_RESET;
         page_latch_ff        <= 1'b0;
         irq_low_ff           <= pse_pkg::IRQ_LOW_RESET;
      end else if (clk_en) begin
         event_enable_mask_ff <= nxt_event_enable_mask;
         event_pending_reg_ff <= nxt_event_pending_reg;
         page_latch_ff        <= nxt_page_latch;
         irq_low_ff           <= nxt_irq_low;
      end
   end

   // Previous sample; three edges pass before both copies hold live data,
   // so a reset in mid-run does not report the old state as a change
   always_ff @(posedge core_clk) begin
      if (rst) begin
         prev_ff <= 18'h00010;
         fill_ff <= 3'b000;
      end else if (clk_en) begin
         prev_ff <= sync_out;
         fill_ff <= {fill_ff[1:0], 1'b1};
      end
   end

   // Bus answer and pin; idle pin is inactive high after reset
   always_ff @(posedge core_clk) begin
      if (rst) begin
         ack_ff     <= 1'b0;
         rdata_ff   <= 32'h0000_0000;
         irq_pin_ff <= 1'b1;
      end else if (clk_en) begin
         ack_ff     <= access;
         irq_pin_ff <= nxt_irq_pin;
         if (rd_fire) begin
            rdata_ff <= nxt_rdata;
         end
      end
   end

   // Waitrequest held high until the answer cycle
   logic wait_ff;
   always_ff @(posedge core_clk) begin
      if (rst) begin
         wait_ff <= 1'b1;
      end else if (clk_en) begin
         wait_ff <= ~access;
      end
   end

   assign avs_waitrequest = wait_ff;
   assign avs_readdata    = rdata_ff;
   assign irq_pin         = irq_pin_ff;
endmodule

// file: test/pse_host_model.sv
// Bus master model of the management host that reads and writes the registers
`timescale 1ns/100ps
module pse_host_model (
   input  wire logic        core_clk,
   output logic      [9:0]  avs_address,
   output logic             avs_read,
   output logic             avs_write,
   output logic      [31:0] avs_writedata,
   output logic      [3:0]  avs_byteenable,
   input  wire logic [31:0] avs_readdata,
   input  wire logic        avs_waitrequest
);
   // Idle bus at time zero
   initial begin
      avs_address = '0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = '0;
      avs_byteenable = 4'h3;
   end
   // One transfer, held until waitrequest is sampled low
   task automatic xfer(input logic wr, input logic [9:0] addr, input logic [15:0] wd,
                       output logic [15:0] rd);
      @(posedge core_clk);
      avs_address <= addr;
      avs_read <= !wr;
      avs_write <= wr;
      avs_writedata <= {16'h0000, wd};
      do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
      rd = avs_readdata[15:0];
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      // Released lines must not keep looking valid
      avs_address <= ~addr;
      avs_writedata <= ~avs_writedata;
   endtask
endmodule

// file: test/pse_top_chk.sv
// Concurrent checks on the bus answer and interrupt pin of the status block
`timescale 1ns/100ps
module pse_top_chk (
   input wire logic        core_clk,
   input wire logic        rst,
   input wire logic [9:0]  avs_address,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0]  avs_byteenable,
   input wire logic [31:0] avs_readdata,
   input wire logic        avs_waitrequest,
   input wire logic        irq_pin
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   // Pin polarity as last written by the host; decides which pin edge is a release
   logic irq_low_ff;
   always_ff @(posedge core_clk) begin
      if (rst) begin
         irq_low_ff <= pse_pkg::IRQ_LOW_RESET;
      end else if (avs_write && !avs_waitrequest && avs_byteenable[1] &&
                   avs_address == pse_pkg::IRQ_CFG_ADDR) begin
         irq_low_ff <= avs_writedata[pse_pkg::IRQ_LOW_BIT];
      end
   end
   // A request taken while the slave is idle, and its answer
   sequence req_s;
      (avs_read || avs_write) && avs_waitrequest;
   endsequence
   sequence ack_s;
      !avs_waitrequest;
   endsequence
   ack_next_a: assert property (req_s |=> ack_s)
      else $error("no answer one cycle after request");
   ack_once_a: assert property (ack_s |=> avs_waitrequest)
      else $error("waitrequest low longer than one cycle");
   ack_cause_a: assert property (ack_s |-> $past(avs_read || avs_write))
      else $error("answer without request");
   upper_zero_a: assert property (ack_s |-> avs_readdata[31:16] == 16'h0000)
      else $error("upper read data not zero");
   rsvd_zero_a: assert property (ack_s ##0 ($past(avs_read) &&
      $past(avs_address) == pse_pkg::ENABLE_ADDR) |-> avs_readdata[9] == 1'b0 &&
      avs_readdata[7] == 1'b0) else $error("reserved enable bits read one");
   rdata_hold_a: assert property (!$past(avs_read) && !$past(rst)
      |-> $stable(avs_readdata)) else $error("read data changed without a read");
   // Reset must leave the pin inactive and the bus idle
   irq_reset_a: assert property (disable iff (1'b0) rst |=> irq_pin &&
      avs_waitrequest && avs_readdata == 32'h0000_0000) else $error("bad state after reset");
   irq_release_a: assert property ((irq_low_ff ? $rose(irq_pin) : $fell(irq_pin))
      |-> $past(!avs_waitrequest))
      else $error("interrupt released without a register access");
endmodule
bind pse_top pse_top_chk u_pse_top_chk (.core_clk(core_clk), .rst(rst),
   .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
   .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
   .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq_pin(irq_pin));

// file: test/tb_top.sv
// Self-checking bench for the status summary and event enable registers
`timescale 1ns/100ps
module tb_top;
   logic        core_clk, rst, avs_read, avs_write, avs_waitrequest, irq_pin;
   logic [9:0]  avs_address;
   logic [31:0] avs_writedata, avs_readdata;
   logic [3:0]  avs_byteenable, cpr;
   logic [1:0]  rate_in;
   logic        fd, nr, lu, cd, ab, gm, dz, p10, jb, ce;
   logic [6:0]  ev;
   logic [15:0] rd;
   int          n_errors, check_count, cyc;
   int          evpos[7] = '{pse_pkg::EV_PAGE, pse_pkg::EV_NEG_FAULT, pse_pkg::EV_NEG_DONE,
                  pse_pkg::EV_FALSE_CAR, pse_pkg::EV_DOWNSHIFT, pse_pkg::EV_WAKE,
                  pse_pkg::EV_MAC_IF_ERR};
   pse_host_model u_pse_host_model (.core_clk(core_clk), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest));
   pse_top u_pse_top (.core_clk(core_clk), .rst(rst), .clk_en(ce),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .rate_in(rate_in),
      .full_duplex_in(fd), .neg_resolved_in(nr), .link_up_in(lu),
      .cross_resolved_pairs_cd(cd), .cross_resolved_pairs_ab(ab), .gig_masking_active(gm),
      .doze_in(dz), .channel_polarity_reversed(cpr), .pol10_correct_in(p10), .jabber_in(jb),
      .page_rx_evt(ev[0]), .neg_fault_evt(ev[1]), .neg_done_evt(ev[2]),
      .false_carrier_evt(ev[3]), .downshift_evt(ev[4]), .wake_packet_evt(ev[5]),
      .mac_if_error_evt(ev[6]), .irq_pin(irq_pin));
   // 250 MHz clock
   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic rd_chk(input logic [9:0] a, input logic [15:0] exp);
      u_pse_host_model.xfer(1'b0, a, 16'h0000, rd);
      check(rd, exp);
   endtask
   task automatic wr(input logic [9:0] a, input logic [15:0] d);
      u_pse_host_model.xfer(1'b1, a, d, rd);
   endtask
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // Drive live state so the status word should read e, then read it twice
   task automatic stat_try(input logic [15:0] e);
      @(posedge core_clk);
      {rate_in, fd, nr, lu, cd, ab, gm, dz, cpr, p10, jb} <= {e[15:13], e[11:0]};
      repeat (4) @(posedge core_clk);
      rd_chk(pse_pkg::STATUS_ADDR, e);
      rd_chk(pse_pkg::STATUS_ADDR, e);
   endtask
   task automatic pulse(input int i);
      @(posedge core_clk);
      ev[i] <= 1'b1;
      @(posedge core_clk);
      ev <= '0;
      repeat (3) @(posedge core_clk);
   endtask
   task automatic t_reset;
      rd_chk(pse_pkg::STATUS_ADDR, 16'h0002);
      rd_chk(pse_pkg::ENABLE_ADDR, 16'h0000);
      rd_chk(10'h3fc, 16'h0000);
      $display("test reset done");
   endtask
   task automatic t_status;
      for (int r = 0; r < 4; r++) stat_try({r[1:0], 14'h0000});
      stat_try(16'haea9);
      stat_try(16'h4156);
      wr(pse_pkg::STATUS_ADDR, 16'hffff);
      rd_chk(pse_pkg::STATUS_ADDR, 16'h4156);
      $display("test status done");
   endtask
   task automatic t_page;
      pulse(0);
      rd_chk(pse_pkg::STATUS_ADDR, 16'h5156);
      rd_chk(pse_pkg::STATUS_ADDR, 16'h4156);
      $display("test page done");
   endtask
   task automatic t_enable;
      wr(pse_pkg::ENABLE_ADDR, 16'hffff);
      rd_chk(pse_pkg::ENABLE_ADDR, 16'hfd7f);
      wr(pse_pkg::ENABLE_ADDR, 16'h0280);
      rd_chk(pse_pkg::ENABLE_ADDR, 16'h0000);
      $display("test enable done");
   endtask
   // Masked events only pend; an enabled one drives the pin low until read
   task automatic t_irq;
      u_pse_host_model.xfer(1'b0, pse_pkg::PENDING_ADDR, 16'h0000, rd);
      for (int i = 0; i < 7; i++) begin
         pulse(i);
         check({15'h0000, irq_pin}, 16'h0001);
         rd_chk(pse_pkg::PENDING_ADDR, 16'h0001 << evpos[i]);
      end
      wr(pse_pkg::ENABLE_ADDR, 16'h8000);
      pulse(1);
      check({15'h0000, irq_pin}, 16'h0000);
      rd_chk(pse_pkg::PENDING_ADDR, 16'h8000);
      repeat (3) @(posedge core_clk);
      check({15'h0000, irq_pin}, 16'h0001);
      $display("test interrupt done");
   endtask
   // Frozen clock enable: an enabled event must leave no trace
   task automatic t_freeze;
      @(posedge core_clk);
      ce <= 1'b0;
      pulse(1);
      ce <= 1'b1;
      check({15'h0000, irq_pin}, 16'h0001);
      rd_chk(pse_pkg::PENDING_ADDR, 16'h0000);
      $display("test freeze done");
   endtask
   // Live link and crossover changes pend as events but stay masked
   task automatic t_live;
      rd_chk(pse_pkg::STATUS_ADDR, 16'h5156);
      stat_try(16'h4756);
      check({15'h0000, irq_pin}, 16'h0001);
      rd_chk(pse_pkg::PENDING_ADDR, (16'h0001 << pse_pkg::EV_LINK) |
             (16'h0001 << pse_pkg::EV_PAIR_SWAP));
      $display("test live done");
   endtask
   // Active-high pin: idle low, high while an enabled event pends
   task automatic t_pol;
      wr(pse_pkg::IRQ_CFG_ADDR, 16'h0000);
      repeat (3) @(posedge core_clk);
      check({15'h0000, irq_pin}, 16'h0000);
      pulse(1);
      check({15'h0000, irq_pin}, 16'h0001);
      rd_chk(pse_pkg::IRQ_CFG_ADDR, 16'h0000);
      rd_chk(pse_pkg::PENDING_ADDR, 16'h8000);
      repeat (3) @(posedge core_clk);
      check({15'h0000, irq_pin}, 16'h0000);
      $display("test polarity done");
   endtask
   // Reset in mid-run: registers back to defaults, no false change events
   task automatic t_rerun;
      @(posedge core_clk);
      rst <= 1'b1;
      repeat (2) @(posedge core_clk);
      rst <= 1'b0;
      rd_chk(pse_pkg::ENABLE_ADDR, 16'h0000);
      rd_chk(pse_pkg::IRQ_CFG_ADDR, 16'h2000);
      rd_chk(pse_pkg::STATUS_ADDR, 16'h4756);
      rd_chk(pse_pkg::PENDING_ADDR, 16'h0000);
      check({15'h0000, irq_pin}, 16'h0001);
      $display("test mid-run reset done");
   endtask
   // Hang guard, far above the few hundred cycles the tests need
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 20000) begin
         n_errors++;
         give_verdict;
      end
   end
   initial begin
      rst = 1'b1;
      {rate_in, fd, nr, lu, cd, ab, gm, dz, cpr, jb} = '0;
      p10 = 1'b1;
      ce = 1'b1;
      ev = '0;
      repeat (20) @(posedge core_clk);
      rst <= 1'b0;
      t_reset;
      t_status;
      t_page;
      t_enable;
      t_irq;
      t_freeze;
      t_live;
      t_pol;
      t_rerun;
      give_verdict;
   end
endmodule
